// ===== src/amc_ctrl.sv
// external asynchronous memory bus controller with apb configuration port
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - consecutive-address bus requests run as bursts on the memory bus
// - burst beats use single-access timing; read turnaround only after last
// - one idle turnaround cycle after a read not followed by consecutive
// - bit 7 of byte-enable mode register selects byte-enable mode
// - byte-enable mode: lane strobes become byte enables, common write enable
// - chip selects and output enable same in both modes
// - byte-enable reads drive all enables low; writes 1, 2 or 4 lanes
// - enable 0 covers data 31:24 down to enable 3 covering 7:0
// - io width field codes 8/16/32 bits, resets to 32 bits
// - io ready-enable bit makes io accesses wait for external ready
// - io error-enable bit honours external bus error; resets cleared
// - four-bit io wait-state field 0 to 15, resets to 15
// - io space reachable only while io enable bit set; resets clear
// - bank 4 writes only while its write-permit bit is set
// - bank 4 width field codes 8/16/32, resets to 8 bits
// - bank 4 separate four-bit write and read waits, reset 15
// - banks 0-3 three-bit write and read waits in second register, reset 7
// - memory ready-enable bit makes bank accesses wait for external ready
// - merge bit makes sub-word writes to wide banks read then write word
module amc_ctrl #(
  parameter logic [1:0] BANK_WIDTH = amc_pkg::W32
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb register port
  input  wire logic [31:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // on-chip bus request and answer
  input  wire logic              req_valid,
  input  wire amc_pkg::amc_req_t req,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output amc_pkg::amc_rsp_t      rsp,
  // external memory pins
  output logic [23:0]            mem_addr,
  output logic [31:0]            mem_data_out,
  input  wire logic [31:0]       mem_data_in,
  output logic                   mem_data_oe_n,
  output logic [4:0]             mem_cs_n,
  output logic                   mem_io_sel_n,
  output logic                   mem_oe_n,
  output logic [3:0]             lane_write_strobe_n,
  output logic                   common_write_enable_n,
  input  wire logic              external_ready_n,
  input  wire logic              external_bus_error_n
);
  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_HOLD, ST_TURN} amc_st_t;
  localparam logic [2:0] SEL_IO   = 3'h5;
  localparam logic [2:0] SEL_NONE = 3'h7;

  // configuration registers
  logic [1:0] io_width_r;
  logic       io_rdy_en_r;
  logic       io_err_en_r;
  logic [3:0] io_wait_states_r;
  logic       io_en_r;
  logic       bank4_write_permit_r;
  logic [1:0] bank4_width_r;
  logic [3:0] bank4_write_waits_r;
  logic [3:0] bank4_read_waits_r;
  logic [2:0] bank_wws_r [amc_pkg::NBANK];
  logic [2:0] bank_rws_r [amc_pkg::NBANK];
  logic       mem_rdy_en_r;
  logic       subword_merge_write_enable_r;
  logic       byte_mode_r;
  logic [31:0] cfg1_r;
  logic [31:0] cfg2_r;

  // access state
  amc_st_t     st_r;
  logic [31:0] addr_r;
  logic [31:0] wdata_r;
  logic [31:0] data_r;
  logic        cur_write_r;
  logic        merge_pend_r;
  logic        burst_r;
  logic [2:0]  sel_r;
  logic [3:0]  en_r;
  logic        rsp_valid_r;
  logic        rsp_err_r;
  logic [3:0]  merge_en_r;
  logic [31:0] prdata_r;

  // decode of the incoming request
  logic [2:0]  req_sel;
  logic [1:0]  req_width;
  logic [3:0]  req_en;
  logic [3:0]  full_en;
  logic        req_merge;
  logic        req_refuse;
  logic [3:0]  req_waits;
  logic        accept;
  logic        cnt_load;
  logic [3:0]  cnt_val;
  logic        cnt_done;
  logic        rdy_en;
  logic        access_ok;
  logic        bus_err;
  logic        apb_wr;
  logic        apb_hit;

  function automatic logic [3:0] lane_mask(input logic [1:0] sz,
                                           input logic [1:0] a,
                                           input logic [1:0] w);
    logic [3:0] m;
    m = 4'h1;
    if (w == amc_pkg::W16) begin
      if (sz == amc_pkg::SZ_BYTE) begin
        m = a[0] ? 4'h2 : 4'h1;
      end else begin
        m = 4'h3;
      end
    end else if (w == amc_pkg::W32) begin
      if (sz == amc_pkg::SZ_BYTE) begin
        m = 4'h1 << a;
      end else if (sz == amc_pkg::SZ_HALF) begin
        m = a[1] ? 4'hC : 4'h3;
      end else begin
        m = 4'hF;
      end
    end
    return m;
  endfunction

  function automatic logic [3:0] wait_sel(input logic [2:0] s,
                                          input logic       wr,
                                          input logic [3:0] io_ws,
                                          input logic [3:0] b4w,
                                          input logic [3:0] b4r,
                                          input logic [2:0] ww,
                                          input logic [2:0] rw);
    logic [3:0] v;
    v = wr ? {1'b0, ww} : {1'b0, rw};
    if (s == SEL_IO) begin
      v = io_ws;
    end else if (s == 3'h4) begin
      v = wr ? b4w : b4r;
    end
    return v;
  endfunction

  always_comb begin
    req_sel = SEL_NONE;
    if (req.addr[31:24] <= amc_pkg::TOP_BANK3) begin
      req_sel = {1'b0, req.addr[25:24]};
    end else if (req.addr[31:24] == amc_pkg::TOP_BANK4) begin
      req_sel = 3'h4;
    end else if (req.addr[31:24] >= amc_pkg::TOP_IO_LO &&
                 req.addr[31:24] <= amc_pkg::TOP_IO_HI) begin
      req_sel = SEL_IO;
    end
  end

  always_comb begin
    req_width = BANK_WIDTH;
    if (req_sel == SEL_IO) begin
      req_width = io_width_r;
    end else if (req_sel == 3'h4) begin
      req_width = bank4_width_r;
    end
  end

  assign req_en  = lane_mask(req.size, req.addr[1:0], req_width);
  assign full_en = lane_mask(amc_pkg::SZ_WORD, 2'h0, req_width);
  // sub-word write to a wide bank becomes read of the word, then full write
  assign req_merge = req.write && subword_merge_write_enable_r &&
                     req_width != amc_pkg::W8 && req_en != full_en;
  assign req_refuse = (req_sel == SEL_NONE) ||
                      (req_sel == SEL_IO && !io_en_r) ||
                      (req_sel == 3'h4 && req.write &&
                       !bank4_write_permit_r);
  assign req_waits = wait_sel(req_sel, req.write && !req_merge,
                              io_wait_states_r, bank4_write_waits_r,
                              bank4_read_waits_r,
                              bank_wws_r[req_sel[1:0]],
                              bank_rws_r[req_sel[1:0]]);

  assign req_ready = (st_r == ST_IDLE);
  assign accept    = req_valid && req_ready && !req_refuse;

  // merge write reloads the write count after the read half
  assign cnt_load = accept || (st_r == ST_TURN && merge_pend_r);
  assign cnt_val  = accept ? req_waits :
                    wait_sel(sel_r, 1'b1, io_wait_states_r,
                             bank4_write_waits_r, bank4_read_waits_r,
                             bank_wws_r[sel_r[1:0]],
                             bank_rws_r[sel_r[1:0]]);

  amc_wait_timer #(
    .W(amc_pkg::REG_WS_W)
  ) u_wait (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (cnt_load),
    .load_val (cnt_val),
    .done     (cnt_done)
  );

  // ready input only stretches past the programmed waits
  assign rdy_en = (sel_r == SEL_IO) ? io_rdy_en_r
                                    : mem_rdy_en_r;
  assign access_ok = cnt_done &&
                     (!rdy_en || !external_ready_n);
  assign bus_err = (sel_r == SEL_IO) && io_err_en_r &&
                   !external_bus_error_n;

  // sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (accept) begin
            st_r <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (bus_err) begin
            st_r <= ST_TURN;
          end else if (access_ok) begin
            if (cur_write_r) begin
              st_r <= ST_HOLD;
            end else if (burst_r && !merge_pend_r) begin
              st_r <= ST_IDLE;
            end else begin
              st_r <= ST_TURN;
            end
          end
        end
        ST_HOLD: begin
          st_r <= ST_IDLE;
        end
        ST_TURN: begin
          st_r <= merge_pend_r ? ST_DATA : ST_IDLE;
        end
      endcase
    end
  end

  // access context and data capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r       <= '0;
      wdata_r      <= '0;
      data_r       <= '0;
      cur_write_r  <= 1'b0;
      merge_pend_r <= 1'b0;
      burst_r      <= 1'b0;
      sel_r        <= SEL_NONE;
      en_r         <= '0;
      merge_en_r   <= '0;
    end else if (accept) begin
      addr_r       <= req.addr;
      wdata_r      <= req.wdata;
      cur_write_r  <= req.write && !req_merge;
      merge_pend_r <= req_merge;
      burst_r      <= req.burst;
      sel_r        <= req_sel;
      en_r         <= req_merge ? full_en : req_en;
      merge_en_r   <= req_en;
    end else if (st_r == ST_DATA && bus_err) begin
      merge_pend_r <= 1'b0;
    end else if (st_r == ST_DATA && !cur_write_r && access_ok) begin
      data_r <= mem_data_in;
      if (merge_pend_r) begin
        for (int i = 0; i < 4; i++) begin
          // lane i carries bits 31-8i down to 24-8i; keep the new bytes
          if (!merge_en_r[i]) begin
            wdata_r[31-8*i -: 8] <= mem_data_in[31-8*i -: 8];
          end
        end
      end
    end else if (st_r == ST_TURN && merge_pend_r) begin
      cur_write_r  <= 1'b1;
      merge_pend_r <= 1'b0;
    end
  end

  // one-cycle answer; a refused request still answers, with error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid_r <= 1'b0;
      rsp_err_r   <= 1'b0;
    end else begin
      rsp_valid_r <= (req_valid && req_ready && req_refuse) ||
                     (st_r == ST_DATA && (bus_err || (access_ok &&
                      !cur_write_r && !merge_pend_r))) ||
                     (st_r == ST_HOLD);
      rsp_err_r   <= (req_valid && req_ready && req_refuse) ||
                     (st_r == ST_DATA && bus_err);
    end
  end
  assign rsp_valid = rsp_valid_r;
  assign rsp       = {data_r, rsp_err_r};

  // pins decode registered state only; the idle turn cycle selects nothing
  wire logic bus_on = (st_r == ST_DATA) || (st_r == ST_HOLD);
  assign mem_cs_n      = (bus_on && sel_r <= 3'h4) ? ~(5'h01 << sel_r)
                                                   : 5'h1F;
  assign mem_io_sel_n  = !(bus_on && sel_r == SEL_IO);
  assign mem_oe_n      = !(st_r == ST_DATA && !cur_write_r);
  assign mem_data_oe_n = !(bus_on && cur_write_r);
  assign mem_addr      = addr_r[23:0];
  assign mem_data_out  = wdata_r;
  assign lane_write_strobe_n = (st_r != ST_DATA) ? 4'hF :
                               cur_write_r ? ~en_r :
                               byte_mode_r ? 4'h0 : 4'hF;
  assign common_write_enable_n = !(st_r == ST_DATA && cur_write_r &&
                                   byte_mode_r);

  // apb port: no wait states
  assign apb_hit = paddr == amc_pkg::CFG1_ADDR ||
                   paddr == amc_pkg::CFG2_ADDR ||
                   paddr == amc_pkg::BEMODE_ADDR;
  assign apb_wr  = psel && penable && pwrite;
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !apb_hit;

  // configuration words; reserved bits read back as written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg1_r <= {3'h0, amc_pkg::IO_WIDTH_RST, 3'h0, amc_pkg::WS4_RST, 1'b0,
                 7'h00, 1'b0, 1'b0, amc_pkg::B4_WIDTH_RST,
                 amc_pkg::WS4_RST, amc_pkg::WS4_RST};
      cfg2_r <= {{8{amc_pkg::WS3_RST}}, 8'h00};
    end else if (apb_wr && paddr == amc_pkg::CFG1_ADDR) begin
      cfg1_r <= pwdata;
    end else if (apb_wr && paddr == amc_pkg::CFG2_ADDR) begin
      cfg2_r <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_mode_r <= 1'b0;
    end else if (apb_wr && paddr == amc_pkg::BEMODE_ADDR) begin
      byte_mode_r <= pwdata[amc_pkg::BEMODE_BIT];
    end
  end

  assign io_width_r           = cfg1_r[amc_pkg::IO_WIDTH_LSB +: 2];
  assign io_rdy_en_r          = cfg1_r[amc_pkg::IO_RDY_BIT];
  assign io_err_en_r          = cfg1_r[amc_pkg::IO_ERR_BIT];
  assign io_wait_states_r     = cfg1_r[amc_pkg::IO_WS_LSB +: 4];
  assign io_en_r              = cfg1_r[amc_pkg::IO_EN_BIT];
  assign bank4_write_permit_r = cfg1_r[amc_pkg::B4_WP_BIT];
  assign bank4_width_r        = cfg1_r[amc_pkg::B4_WIDTH_LSB +: 2];
  assign bank4_write_waits_r  = cfg1_r[amc_pkg::B4_WWS_LSB +: 4];
  assign bank4_read_waits_r   = cfg1_r[amc_pkg::B4_RWS_LSB +: 4];
  assign mem_rdy_en_r         = cfg2_r[amc_pkg::MEM_RDY_BIT];
  assign subword_merge_write_enable_r = cfg2_r[amc_pkg::RMW_BIT];
  always_comb begin
    for (int i = 0; i < amc_pkg::NBANK; i++) begin
      bank_wws_r[i] = cfg2_r[amc_pkg::B_WWS_LSB0 +
                             amc_pkg::B_FIELD_STEP * i +: 3];
      bank_rws_r[i] = cfg2_r[amc_pkg::B_RWS_LSB0 +
                             amc_pkg::B_FIELD_STEP * i +: 3];
    end
  end

  // read data is taken in the setup cycle so it stands through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (psel && !penable) begin
      prdata_r <= (paddr == amc_pkg::CFG1_ADDR) ? cfg1_r :
                  (paddr == amc_pkg::CFG2_ADDR) ? cfg2_r :
                  (paddr == amc_pkg::BEMODE_ADDR) ?
                  (32'(byte_mode_r) << amc_pkg::BEMODE_BIT) : '0;
    end
  end
  assign prdata = prdata_r;
endmodule
`default_nettype wire

// ===== src/amc_pkg.sv
// package: register map, field layout, reset values and types of the controller
package amc_pkg;
  // register byte addresses
  localparam logic [31:0] CFG1_ADDR   = 32'h0800_0000;
  localparam logic [31:0] CFG2_ADDR   = 32'h8000_0004;
  localparam logic [31:0] BEMODE_ADDR = 32'h8000_0010;
  localparam logic [31:0] STATUS_ADDR = 32'h8000_0014;
  // io_and_bank4_config fields
  localparam int IO_WIDTH_LSB = 27;
  localparam int IO_RDY_BIT   = 26;
  localparam int IO_ERR_BIT   = 25;
  localparam int IO_WS_LSB    = 20;
  localparam int IO_EN_BIT    = 19;
  localparam int B4_WP_BIT    = 11;
  localparam int B4_WIDTH_LSB = 8;
  localparam int B4_WWS_LSB   = 4;
  localparam int B4_RWS_LSB   = 0;
  // bank_wait_and_ready_config fields
  localparam int B_WWS_LSB0   = 11;
  localparam int B_RWS_LSB0   = 8;
  localparam int B_FIELD_STEP = 6;
  localparam int MEM_RDY_BIT  = 3;
  localparam int RMW_BIT      = 2;
  // byte_enable_mode_register field
  localparam int BEMODE_BIT   = 7;
  // reset values
  localparam logic [1:0] IO_WIDTH_RST = 2'h2;
  localparam logic [1:0] B4_WIDTH_RST = 2'h0;
  localparam logic [3:0] WS4_RST      = 4'hF;
  localparam logic [2:0] WS3_RST      = 3'h7;
  // width codes and transfer sizes
  localparam logic [1:0] W8  = 2'h0;
  localparam logic [1:0] W16 = 2'h1;
  localparam logic [1:0] W32 = 2'h2;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  // region top bytes
  localparam logic [7:0] TOP_BANK4  = 8'h10;
  localparam logic [7:0] TOP_IO_LO  = 8'h20;
  localparam logic [7:0] TOP_IO_HI  = 8'h6F;
  localparam logic [7:0] TOP_BANK3  = 8'h03;
  localparam int REG_WS_W = 4;
  localparam int NBANK    = 4;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        write;
    logic [1:0]  size;
    logic        burst;
  } amc_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic        err;
  } amc_rsp_t;
endpackage

// ===== src/amc_wait_timer.sv
// wait-state down counter: loads a count and flags when it has run out
`timescale 1ns/1ps
`default_nettype none
module amc_wait_timer #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // status
  output logic              done
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  assign done = (cnt_r == '0);
endmodule
`default_nettype wire

// ===== testbench/amc_mem_model.sv
// behavioural asynchronous memory / io device on the external bus
`timescale 1ns/1ps
`default_nettype none
module amc_mem_model (
  // clock and commands from the bench
  input wire logic        pclk,
  input wire logic        slow,
  input wire logic        err_cmd,
  // bus pins
  input wire logic [23:0] mem_addr,
  input wire logic [31:0] mem_data_out,
  input wire logic [4:0]  mem_cs_n,
  input wire logic        mem_io_sel_n,
  input wire logic        mem_oe_n,
  input wire logic [3:0]  lane_write_strobe_n,
  output logic [31:0]     mem_data_in,
  output logic            external_ready_n,
  output logic            external_bus_error_n
);
  logic [31:0] mem [64];
  logic [31:0] last_r = '0;
  int          cnt = 0;
  wire         sel = !(&mem_cs_n) || !mem_io_sel_n;
  wire [5:0]   ix = mem_addr[7:2];
  always @(posedge pclk) begin
    cnt <= sel ? cnt + 1 : 0;
    for (int i = 0; i < 4; i++)
      if (sel && mem_oe_n && !lane_write_strobe_n[i])
        mem[ix][31-8*i -: 8] <= mem_data_out[31-8*i -: 8];
    if (!mem_oe_n)
      last_r <= mem[ix];
  end
  // a released bus shows the inverse of the last word, so stale reads fail
  assign mem_data_in = (sel && !mem_oe_n) ? mem[ix] : ~last_r;
  assign external_ready_n = slow && cnt < 3;
  assign external_bus_error_n = !(err_cmd && !mem_io_sel_n);
endmodule
`default_nettype wire

// ===== testbench/amc_monitor.sv
// checker: port-level assertions for the memory bus controller
`timescale 1ns/1ps
`default_nettype none
module amc_monitor (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb port
  input wire logic [31:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // memory pins
  input wire logic [4:0]  mem_cs_n,
  input wire logic        mem_io_sel_n,
  input wire logic        mem_oe_n,
  input wire logic        mem_data_oe_n,
  input wire logic [3:0]  lane_write_strobe_n,
  input wire logic        common_write_enable_n
);
  logic wp_r;
  logic ioen_r;
  logic be_r;
  wire  wr = psel && penable && pready && pwrite;
  // config shadows, snooped from completed writes since no register is a port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r <= 1'b0;
      ioen_r <= 1'b0;
      be_r <= 1'b0;
    end else if (wr && paddr == amc_pkg::CFG1_ADDR) begin
      wp_r <= pwdata[amc_pkg::B4_WP_BIT];
      ioen_r <= pwdata[amc_pkg::IO_EN_BIT];
    end else if (wr && paddr == amc_pkg::BEMODE_ADDR) begin
      be_r <= pwdata[amc_pkg::BEMODE_BIT];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_io_disabled: assert property (
    !ioen_r |-> mem_io_sel_n) else $error("io select while io disabled");
  a_b4_protect: assert property (
    !wp_r && !mem_cs_n[4] && mem_oe_n |->
      &lane_write_strobe_n && common_write_enable_n)
    else $error("bank 4 written while protected");
  a_std_mode: assert property (
    !be_r |-> common_write_enable_n) else $error("common enable in std mode");
  a_be_lanes: assert property (
    be_r && !common_write_enable_n |-> lane_write_strobe_n != 4'hF)
    else $error("write without byte enable");
  a_read_lanes: assert property (
    !mem_oe_n |-> lane_write_strobe_n inside {4'hF, 4'h0})
    else $error("partial lanes during read");
  a_write_count: assert property (
    !common_write_enable_n |->
      $countones(~lane_write_strobe_n) inside {1, 2, 4})
    else $error("bad byte enable count");
  a_we_excl: assert property (
    !common_write_enable_n |-> mem_oe_n) else $error("write during read");
  a_sel_excl: assert property (
    !mem_io_sel_n |-> &mem_cs_n) else $error("io and bank selected");
  a_turnaround: assert property (
    $rose(mem_oe_n) |-> mem_data_oe_n) else $error("no turnaround cycle");
endmodule
bind amc_ctrl amc_monitor u_mon (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .pready, .mem_cs_n, .mem_io_sel_n, .mem_oe_n,
  .mem_data_oe_n, .lane_write_strobe_n, .common_write_enable_n);
`default_nettype wire

// ===== testbench/tb.sv
// testbench: apb configuration and bus transfers against a memory model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
  begin \
    n_compared++; \
    if ((a) !== (e)) begin \
      mismatches++; \
      $display("BAD t=%0t got %h want %h", $time, a, e); \
    end \
  end
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic req_valid = 0, slow = 0, err_cmd = 0;
  logic [31:0] paddr = '0, pwdata = '0, rd;
  amc_pkg::amc_req_t req = '0;
  amc_pkg::amc_rsp_t rsp, s;
  wire pready, pslverr, req_ready, rsp_valid, mem_data_oe_n, mem_io_sel_n;
  wire mem_oe_n, common_write_enable_n, external_ready_n;
  wire external_bus_error_n;
  wire [31:0] prdata, mem_data_out, mem_data_in;
  wire [23:0] mem_addr;
  wire [4:0] mem_cs_n;
  wire [3:0] lane_write_strobe_n;
  int mismatches = 0, n_compared = 0, oe_cnt = 0, n0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (!mem_oe_n) oe_cnt <= oe_cnt + 1;
  amc_ctrl dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pready, .prdata, .pslverr, .req_valid, .req, .req_ready, .rsp_valid,
    .rsp, .mem_addr, .mem_data_out, .mem_data_in, .mem_data_oe_n,
    .mem_cs_n, .mem_io_sel_n, .mem_oe_n, .lane_write_strobe_n,
    .common_write_enable_n, .external_ready_n, .external_bus_error_n);
  amc_mem_model u_mem (.pclk, .slow, .err_cmd, .mem_addr, .mem_data_out,
    .mem_cs_n, .mem_io_sel_n, .mem_oe_n, .lane_write_strobe_n,
    .mem_data_in, .external_ready_n, .external_bus_error_n);
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    `CHK(pready, 1'b1)
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic op(input logic w, input logic [31:0] a, d, input logic b,
                    input logic [1:0] sz);
    int n;
    logic got;
    n = 0;
    req <= '{addr: a, wdata: d, write: w, size: sz, burst: b};
    req_valid <= 1;
    do begin
      @(posedge pclk);
      n++;
      if (req_ready === 1'b1) req_valid <= 0;
      got = rsp_valid;
      s = rsp;
    end while (got !== 1'b1 && n < 300);
    `CHK(got, 1'b1)
    @(posedge pclk);
  endtask
  // whole sequence needs well under 5000 cycles; four times that is a hang
  initial begin
    #200us;
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, amc_pkg::CFG1_ADDR, 0, rd);
    `CHK(rd & 32'h1EF8_0BFF, 32'h10F0_00FF)
    apb(0, amc_pkg::CFG2_ADDR, 0, rd);
    `CHK(rd & 32'hFFFF_FF0C, 32'hFFFF_FF00)
    apb(0, 32'h8000_0020, 0, rd); // unmapped place must still answer
    apb(1, amc_pkg::CFG2_ADDR, 32'h0000_0008, rd);
    apb(0, amc_pkg::CFG2_ADDR, 0, rd);
    `CHK(rd & 32'hFFFF_FF0C, 32'h0000_0008)
    op(1, 32'h40, 32'h1234_5678, 0, amc_pkg::SZ_WORD);
    oe_cnt = 0;
    op(0, 32'h40, 0, 0, amc_pkg::SZ_WORD);
    `CHK(s.rdata, 32'h1234_5678)
    n0 = oe_cnt;
    slow <= 1;
    oe_cnt = 0;
    op(0, 32'h40, 0, 0, amc_pkg::SZ_WORD);
    `CHK(s.rdata, 32'h1234_5678)
    `CHK(oe_cnt > n0, 1'b1)
    slow <= 0;
    apb(1, amc_pkg::CFG2_ADDR, 32'h0000_0508, rd);
    oe_cnt = 0;
    op(0, 32'h40, 0, 0, amc_pkg::SZ_WORD);
    `CHK(oe_cnt - n0, 5)
    for (int i = 0; i < 2; i++)
      op(1, 32'h80 + 4 * i, 32'hA5A5_0000 + i, 1, amc_pkg::SZ_WORD);
    for (int i = 0; i < 2; i++) begin
      op(0, 32'h80 + 4 * i, 0, i == 0, amc_pkg::SZ_WORD);
      `CHK(s.rdata, 32'hA5A5_0000 + i)
    end
    apb(1, amc_pkg::BEMODE_ADDR, 32'h0000_0080, rd);
    op(1, 32'h40, 32'h0F1E_2D3C, 0, amc_pkg::SZ_WORD);
    op(1, 32'h80, 32'h5A5A_1111, 0, amc_pkg::SZ_HALF);
    op(0, 32'h40, 0, 0, amc_pkg::SZ_WORD);
    `CHK(s.rdata, 32'h0F1E_2D3C)
    op(0, 32'h80, 0, 0, amc_pkg::SZ_WORD);
    `CHK(s.rdata, 32'h5A5A_0000)
    apb(1, amc_pkg::BEMODE_ADDR, 32'h0000_0000, rd);
    apb(1, amc_pkg::CFG1_ADDR, 32'h0000_0A00, rd);
    op(1, 32'h1000_0000, 32'h600D_0001, 0, amc_pkg::SZ_WORD);
    apb(1, amc_pkg::CFG1_ADDR, 32'h0000_0200, rd);
    op(1, 32'h1000_0000, 32'h0BAD_0002, 0, amc_pkg::SZ_WORD);
    `CHK(s.err, 1'b1)
    op(0, 32'h1000_0000, 0, 0, amc_pkg::SZ_WORD);
    `CHK(s.rdata, 32'h600D_0001)
    op(1, 32'h2000_0000, 32'h1111_2222, 0, amc_pkg::SZ_WORD);
    `CHK(s.err, 1'b1)
    apb(1, amc_pkg::CFG1_ADDR, 32'h1228_0200, rd);
    err_cmd <= 1;
    op(0, 32'h2000_0000, 0, 0, amc_pkg::SZ_WORD);
    `CHK(s.err, 1'b1)
    err_cmd <= 0;
    slow <= 1;
    apb(1, amc_pkg::CFG1_ADDR, 32'h1628_0200, rd);
    op(1, 32'h2000_0000, 32'h3C3C_4B4B, 0, amc_pkg::SZ_WORD);
    op(0, 32'h2000_0000, 0, 0, amc_pkg::SZ_WORD);
    `CHK(s.rdata, 32'h3C3C_4B4B)
    `CHK(s.err, 1'b0)
    slow <= 0;
    apb(1, amc_pkg::CFG2_ADDR, 32'h0000_000C, rd);
    op(1, 32'h40, 32'h9900_0000, 0, amc_pkg::SZ_BYTE);
    op(0, 32'h40, 0, 0, amc_pkg::SZ_WORD);
    `CHK(s.rdata, 32'h991E_2D3C)
    end_sim();
  end
endmodule
`default_nettype wire
